// ==== irm_pkg.sv ====
// Package for the infrared transceiver host-side mode controller.
// Assumes a single 125 MHz system clock; no software registers.
package irm_pkg;
    // Clock period in picoseconds.
    localparam int unsigned CLK_PERIOD_PS = 8000;
    // Setup and hold time of the programming sequence, in nanoseconds.
    localparam int unsigned T_SETUP_NS    = 200;
    localparam int unsigned T_HOLD_NS     = 200;
    // Longest transmit high pulse allowed, in nanoseconds.
    localparam int unsigned T_MAXPULSE_NS = 80000;
    // Strictly more than the printed time: floor plus one cycle.
    localparam int unsigned SETUP_CYC = (T_SETUP_NS * 1000) / CLK_PERIOD_PS + 1;
    localparam int unsigned HOLD_CYC  = (T_HOLD_NS * 1000) / CLK_PERIOD_PS + 1;
    // Longest time rounds down.
    localparam int unsigned MAXPULSE_CYC =
        (T_MAXPULSE_NS * 1000) / CLK_PERIOD_PS;
    // Counter width for the sequence timer.
    localparam int unsigned CNT_W = 16;
    // Mode encodings on the transmit pin during programming.
    localparam logic MODE_LOW  = 1'b0;
    localparam logic MODE_HIGH = 1'b1;
    // Reset value of the believed device mode.
    localparam logic MODE_RESET = MODE_LOW;

    // Sequencer states, Gray coded along the path.
    typedef enum logic [2:0] {
        IRM_IDLE  = 3'b000,
        IRM_SDHI  = 3'b001,
        IRM_SETUP = 3'b011,
        IRM_HOLD  = 3'b010,
        IRM_DONE  = 3'b110
    } irm_state_e;
endpackage : irm_pkg

// ==== irm_timer.sv ====
// Cycle down-counter for the mode controller.
// Assumes synchronous load and a shared clock enable.
`timescale 1ns/1ps
module irm_timer #(
    parameter int unsigned W = 16
) (
    input  wire logic         i_sys_clk,
    input  wire logic         i_sys_rst,
    input  wire logic         i_ce,
    input  wire logic         i_load,
    input  wire logic [W-1:0] i_value,
    output logic              o_zero
);
    logic [W-1:0] cnt_reg;

    // Loads a count and runs down to zero.
    always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            cnt_reg <= '0;
        end else if (i_ce) begin
            if (i_load) begin
                cnt_reg <= i_value;
            end else if (cnt_reg != '0) begin
                cnt_reg <= cnt_reg - 1'b1;
            end
        end
    end

    // Zero flag compares the counter itself.
    assign o_zero = (cnt_reg == '0);
endmodule : irm_timer

// ==== irm_ctrl.sv ====
// Host-side controller for an infrared transceiver's bandwidth mode.
// Drives transmit, shutdown and the static mode pin; samples receive.
// Assumes all pin inputs are synchronous to i_sys_clk.
// The setup and hold counts exceed the minimum programming times by one
// cycle; the pulse limit keeps a stuck transmit from driving the emitter.
// With USE_STATIC set, the mode pin is loaded and no sequence is run.
`timescale 1ns/1ps
module irm_ctrl #(
    parameter int unsigned SETUP_CYC    = irm_pkg::SETUP_CYC,
    parameter int unsigned HOLD_CYC     = irm_pkg::HOLD_CYC,
    parameter int unsigned MAXPULSE_CYC = irm_pkg::MAXPULSE_CYC,
    parameter bit          USE_STATIC   = 1'b0
) (
    input  wire logic i_sys_clk,
    input  wire logic i_sys_rst,
    input  wire logic i_ce,
    input  wire logic i_mode_req,
    input  wire logic i_mode_high,
    input  wire logic i_shutdown_req,
    input  wire logic i_tx_data,
    input  wire logic i_rxd,
    output logic      o_txd,
    output logic      o_shutdown_in,
    output logic      o_mode_pin,
    output logic      o_mode_high,
    output logic      o_busy,
    output logic      o_done,
    output logic      o_rx_data,
    output logic      o_tx_overlong
);
    localparam int unsigned CW = irm_pkg::CNT_W;

    irm_pkg::irm_state_e state_reg;
    irm_pkg::irm_state_e state_next;
    logic                target_reg;
    logic                tmr_load;
    logic [CW-1:0]       tmr_value;
    logic                tmr_zero;
    logic [CW-1:0]       hi_cnt_reg;
    logic                tx_gate;
    logic                tx_quiet;
    logic                sd_release;
    logic                sd_hold_zero;

    irm_timer #(
        .W(CW)
    ) u_timer (
        .i_sys_clk(i_sys_clk),
        .i_sys_rst(i_sys_rst),
        .i_ce     (i_ce),
        .i_load   (tmr_load),
        .i_value  (tmr_value),
        .o_zero   (tmr_zero)
    );

    // A user shutdown release is a falling shutdown edge too, so the
    // transceiver latches the transmit level there. Transmit is low at
    // that edge, which selects the low bandwidth mode.
    assign sd_release = (state_next == irm_pkg::IRM_IDLE)
        && o_shutdown_in && !i_shutdown_req;

    // Times the transmit hold after a user shutdown release, so user data
    // cannot move transmit within the hold window of that edge.
    irm_timer #(
        .W(CW)
    ) u_sd_timer (
        .i_sys_clk(i_sys_clk),
        .i_sys_rst(i_sys_rst),
        .i_ce     (i_ce),
        .i_load   (sd_release),
        .i_value  (CW'(HOLD_CYC)),
        .o_zero   (sd_hold_zero)
    );

    // Next state of the programming sequence. Shutdown rises with the target
    // level on transmit, which then stands for the setup count, shutdown
    // falls to latch it, and transmit holds for the hold count before user
    // data is passed again. Requests that arrive while a sequence runs are
    // dropped without notice.
    always_comb begin
        state_next = state_reg;
        tmr_load   = 1'b0;
        tmr_value  = '0;
        case (state_reg)
            irm_pkg::IRM_IDLE: begin
                if (i_mode_req && !USE_STATIC) begin
                    state_next = irm_pkg::IRM_SDHI;
                end
            end
            irm_pkg::IRM_SDHI: begin
                state_next = irm_pkg::IRM_SETUP;
                tmr_load   = 1'b1;
                tmr_value  = CW'(SETUP_CYC);
            end
            irm_pkg::IRM_SETUP: begin
                if (tmr_zero) begin
                    state_next = irm_pkg::IRM_HOLD;
                    tmr_load   = 1'b1;
                    tmr_value  = CW'(HOLD_CYC);
                end
            end
            irm_pkg::IRM_HOLD: begin
                if (tmr_zero) begin
                    state_next = irm_pkg::IRM_DONE;
                end
            end
            irm_pkg::IRM_DONE: begin
                state_next = irm_pkg::IRM_IDLE;
            end
            default: begin
                state_next = irm_pkg::IRM_IDLE;
            end
        endcase
    end

    // State register.
    always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            state_reg <= irm_pkg::IRM_IDLE;
        end else if (i_ce) begin
            state_reg <= state_next;
        end
    end

    // Captures the requested mode when a sequence starts.
    // A request seen while busy does not disturb the captured target.
    always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            target_reg <= irm_pkg::MODE_RESET;
        end else if (i_ce) begin
            if (state_reg == irm_pkg::IRM_IDLE && i_mode_req) begin
                target_reg <= i_mode_high;
            end
        end
    end

    // Tracks the mode the transceiver holds; low after reset.
    // In static mode the pin is the mode; otherwise the falling edge decides.
    always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_mode_high <= irm_pkg::MODE_RESET;
            o_mode_pin  <= irm_pkg::MODE_LOW;
        end else if (i_ce) begin
            if (USE_STATIC) begin
                if (i_mode_req) begin
                    o_mode_pin  <= i_mode_high;
                    o_mode_high <= i_mode_high;
                end
            end else if (state_reg == irm_pkg::IRM_SETUP && tmr_zero) begin
                o_mode_high <= target_reg;
            end else if (sd_release) begin
                o_mode_high <= irm_pkg::MODE_LOW;
            end
        end
    end

    // Counts steady transmit high time so pulses stay bounded.
    // The count saturates, so a long pulse stays cut until transmit drops or the shutdown pin rises.
    always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            hi_cnt_reg <= '0;
        end else if (i_ce) begin
            if (!i_tx_data || o_shutdown_in) begin
                hi_cnt_reg <= '0;
            end else if (hi_cnt_reg != CW'(MAXPULSE_CYC)) begin
                hi_cnt_reg <= hi_cnt_reg + 1'b1;
            end
        end
    end

    // Data gate: transmit passes only below the longest pulse.
    // Gating from the registered count keeps the cut on a clean edge.
    assign tx_gate = i_tx_data && (hi_cnt_reg != CW'(MAXPULSE_CYC));

    // Transmit stays low in shutdown, at the release edge and through the
    // hold count after it.
    assign tx_quiet = i_shutdown_req || o_shutdown_in || !sd_hold_zero;

    // Drives the transceiver pins from the sequence and user data.
    always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_txd         <= 1'b0;
            o_shutdown_in <= 1'b0;
        end else if (i_ce) begin
            case (state_next)
                irm_pkg::IRM_SDHI: begin
                    // Target is captured at this same edge, so take the
                    // request itself and avoid a stale level on transmit.
                    o_shutdown_in <= 1'b1;
                    o_txd         <= i_mode_high;
                end
                irm_pkg::IRM_SETUP: begin
                    o_shutdown_in <= 1'b1;
                    o_txd         <= target_reg;
                end
                irm_pkg::IRM_HOLD: begin
                    o_shutdown_in <= 1'b0;
                    o_txd         <= target_reg;
                end
                default: begin
                    o_shutdown_in <= i_shutdown_req;
                    o_txd         <= tx_quiet ? 1'b0 : tx_gate;
                end
            endcase
        end
    end

    // Status flags and receive sample.
    // Done pulses for one cycle as busy falls.
    always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_busy        <= 1'b0;
            o_done        <= 1'b0;
            o_rx_data     <= 1'b0;
            o_tx_overlong <= 1'b0;
        end else if (i_ce) begin
            o_busy <= (state_next != irm_pkg::IRM_IDLE);
            o_done <= (state_reg == irm_pkg::IRM_DONE);
            // Receive is active low and meaningless in shutdown or while
            // transmitting; it is reported high-active when valid.
            o_rx_data <= !o_shutdown_in && !o_txd && !i_rxd;
            o_tx_overlong <= i_tx_data
                && (hi_cnt_reg == CW'(MAXPULSE_CYC));
        end
    end
endmodule : irm_ctrl

// ==== irm_assertions.sv ====
// Checker for the mode controller's programming pins.
// Bound to irm_ctrl and sees only its ports.
`timescale 1ns/1ps
module irm_assertions #(
    parameter int unsigned SETUP_CYC  = irm_pkg::SETUP_CYC,
    parameter int unsigned HOLD_CYC   = irm_pkg::HOLD_CYC,
    parameter bit          USE_STATIC = 1'b0
) (
    input wire logic i_sys_clk,
    input wire logic i_sys_rst,
    input wire logic i_ce,
    input wire logic i_mode_req,
    input wire logic o_txd,
    input wire logic o_shutdown_in,
    input wire logic o_mode_pin,
    input wire logic o_mode_high,
    input wire logic o_busy
);
    int setup_reg;
    int hold_reg;
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_sys_rst);
    // A programming edge is a shutdown fall inside a sequence.
    sequence prog_fall;
        $fell(o_shutdown_in) && o_busy;
    endsequence
    // Counts steady setup cycles and the hold left after any fall.
    always_ff @(posedge i_sys_clk) begin
        setup_reg <= (o_shutdown_in && $stable(o_txd)) ? setup_reg + 1 : 0;
        hold_reg  <= i_sys_rst ? 0 :
                     $fell(o_shutdown_in) ? int'(HOLD_CYC) :
                     (hold_reg > 0) ? hold_reg - 1 : 0;
    end
    req_start_a: assert property (
        !USE_STATIC && i_ce && i_mode_req && !o_busy
        |=> o_busy && o_shutdown_in)
        else $error("mode request not started");
    setup_time_a: assert property (
        prog_fall |-> setup_reg >= int'(SETUP_CYC) - 1)
        else $error("shutdown fell before setup time");
    hold_time_a: assert property (
        hold_reg > 0 |-> $stable(o_txd))
        else $error("transmit moved inside hold time");
    mode_track_a: assert property (
        prog_fall |-> o_mode_high == o_txd)
        else $error("believed mode differs from latched level");
    static_pin_a: assert property (
        !USE_STATIC |-> !o_mode_pin)
        else $error("static mode pin moved");
endmodule : irm_assertions

bind irm_ctrl irm_assertions #(
    .SETUP_CYC(SETUP_CYC), .HOLD_CYC(HOLD_CYC), .USE_STATIC(USE_STATIC)
) i_irm_assertions (.i_sys_clk, .i_sys_rst, .i_ce, .i_mode_req, .o_txd,
    .o_shutdown_in, .o_mode_pin, .o_mode_high, .o_busy);

// ==== irm_xcvr_model.sv ====
// Behavioural model of the transceiver's digital pins.
// Driven by the controller's pins; light comes from the bench.
`timescale 1ns/1ps
module irm_xcvr_model (
    input  wire logic i_txd,
    input  wire logic i_shutdown_in,
    input  wire logic i_mode_pin,
    input  wire logic i_light,
    output logic      o_rxd,
    output logic      o_emit,
    output logic      o_mode_high,
    output logic      o_viol
);
    realtime tx_t   = 0.0;
    realtime fall_t = -1.0e6;
    logic    latch_reg = 1'b0;
    initial o_viol = 1'b0;
    // Flags a transmit change that comes too soon after a fall.
    always @(i_txd) begin
        if ($realtime - fall_t <= 200.0)
            o_viol = 1'b1;
        tx_t = $realtime;
    end
    // A falling shutdown latches the transmit level as the mode.
    always @(negedge i_shutdown_in) begin
        if ($realtime - tx_t <= 200.0 && $realtime > 0.0)
            o_viol = 1'b1;
        if ($realtime > 0.0)
            latch_reg = i_txd;
        fall_t = $realtime;
    end
    // Receive is pulled up in shutdown and while transmitting.
    assign o_rxd = !(!i_shutdown_in && !i_txd && i_light);
    assign o_emit = !i_shutdown_in && i_txd;
    assign o_mode_high = latch_reg | i_mode_pin;
endmodule : irm_xcvr_model

// ==== testbench.sv ====
// Self-checking bench for irm_ctrl against the transceiver model.
// One 125 MHz clock; inputs change on the falling edge.
`timescale 1ns/1ps
module testbench;
    logic i_sys_clk = 1'b0;
    logic i_sys_rst = 1'b1;
    logic i_ce = 1'b1;
    logic i_mode_req = 1'b0;
    logic i_mode_high = 1'b0;
    logic i_shutdown_req = 1'b0;
    logic i_tx_data = 1'b0;
    logic light = 1'b0;
    logic o_txd, o_shutdown_in, o_mode_pin, o_mode_high;
    logic o_busy, o_done, o_rx_data, o_tx_overlong;
    logic rxd, emit, dev_mode, viol;
    logic st_pin, st_mode;
    int   fail_count = 0;
    int   comparisons = 0;
    int   cycles = 0;
    // Clock generator.
    always #4 i_sys_clk = ~i_sys_clk;
    irm_ctrl #(.MAXPULSE_CYC(50)) i_irm_ctrl (.i_sys_clk, .i_sys_rst,
        .i_ce, .i_mode_req, .i_mode_high, .i_shutdown_req, .i_tx_data,
        .i_rxd(rxd), .o_txd, .o_shutdown_in, .o_mode_pin, .o_mode_high,
        .o_busy, .o_done, .o_rx_data, .o_tx_overlong);
    // Static pin variant: only its mode outputs are watched.
    irm_ctrl #(.MAXPULSE_CYC(50), .USE_STATIC(1'b1)) i_irm_ctrl_static (
        .i_sys_clk, .i_sys_rst, .i_ce, .i_mode_req, .i_mode_high,
        .i_shutdown_req, .i_tx_data, .i_rxd(rxd), .o_txd(),
        .o_shutdown_in(), .o_mode_pin(st_pin), .o_mode_high(st_mode),
        .o_busy(), .o_done(), .o_rx_data(), .o_tx_overlong());
    irm_xcvr_model i_irm_xcvr_model (.i_txd(o_txd),
        .i_shutdown_in(o_shutdown_in), .i_mode_pin(o_mode_pin),
        .i_light(light), .o_rxd(rxd), .o_emit(emit),
        .o_mode_high(dev_mode), .o_viol(viol));
    // Compares one bit and counts the result.
    task automatic chk(input string name, input logic exp, input logic got);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %b seen %b", name, exp, got);
        end
    endtask : chk
    // Prints the verdict and ends the run.
    task automatic results;
        if (fail_count == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : results
    // Cuts a hang short.
    always @(posedge i_sys_clk) begin
        cycles++;
        if (cycles == 3000) begin
            fail_count++;
            results();
        end
    end
    // Mode change with an opposite request arriving while busy.
    task automatic t_mode(input logic hi);
        int n;
        i_mode_high = hi;
        i_mode_req = 1'b1;
        @(negedge i_sys_clk);
        i_mode_high = ~hi;
        @(negedge i_sys_clk);
        i_mode_req = 1'b0;
        chk("busy", 1'b1, o_busy);
        for (n = 0; n < 200 && o_done !== 1'b1; n++)
            @(negedge i_sys_clk);
        chk("done", 1'b1, o_done);
        chk("ctrl mode", hi, o_mode_high);
        chk("dev mode", hi, dev_mode);
        chk("timing", 1'b0, viol);
        chk("static pin", ~hi, st_pin);
        chk("static mode", ~hi, st_mode);
        @(negedge i_sys_clk);
        chk("idle", 1'b0, o_busy);
    endtask : t_mode
    // Receive, transmit and the long pulse cut in the current mode.
    task automatic t_link;
        light = 1'b1;
        repeat (3) @(negedge i_sys_clk);
        chk("rx on", 1'b1, o_rx_data);
        i_tx_data = 1'b1;
        repeat (3) @(negedge i_sys_clk);
        chk("emit", 1'b1, emit);
        chk("rx off", 1'b0, o_rx_data);
        repeat (52) @(negedge i_sys_clk);
        chk("overlong", 1'b1, o_tx_overlong);
        chk("txd cut", 1'b0, o_txd);
        i_tx_data = 1'b0;
        light = 1'b0;
        repeat (3) @(negedge i_sys_clk);
    endtask : t_link
    // User shutdown silences both directions; its release latches low mode.
    task automatic t_sd;
        light = 1'b1;
        i_tx_data = 1'b1;
        i_shutdown_req = 1'b1;
        repeat (3) @(negedge i_sys_clk);
        chk("sd pin", 1'b1, o_shutdown_in);
        chk("emit off", 1'b0, emit);
        chk("rx gated", 1'b0, o_rx_data);
        repeat (40) @(negedge i_sys_clk);
        i_shutdown_req = 1'b0;
        light = 1'b0;
        repeat (3) @(negedge i_sys_clk);
        chk("sd hold", 1'b0, o_txd);
        repeat (27) @(negedge i_sys_clk);
        chk("sd emit", 1'b1, emit);
        chk("sd mode", 1'b0, o_mode_high);
        chk("sd dev mode", 1'b0, dev_mode);
        chk("sd timing", 1'b0, viol);
        i_tx_data = 1'b0;
        repeat (40) @(negedge i_sys_clk);
    endtask : t_sd
    // Main sequence.
    initial begin
        repeat (3) @(negedge i_sys_clk);
        i_sys_rst = 1'b0;
        chk("reset mode", 1'b0, o_mode_high);
        chk("dev default", 1'b0, dev_mode);
        chk("static pin", 1'b0, o_mode_pin);
        chk("static reset", 1'b0, st_pin);
        t_link();
        t_mode(1'b1);
        t_link();
        t_mode(1'b0);
        t_sd();
        t_mode(1'b1);
        t_sd();
        results();
    end
endmodule : testbench
